//--- rtl/match_capture_counter_timer.sv
// Counter-timer with prescaler, four matches, one capture, AXI4-Lite registers
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Chip holds two 32-bit and two 16-bit instances; width is a parameter.
// - A programmable prescaler divides counting events before the count advances.
// - Timer mode advances on clock cycles, scaled by the prescaler.
// - Counter mode advances on chosen edges of the count input instead.
// - Four match registers are compared against the count on each counting tick.
// - Match without stop or reset lets counting continue, optional interrupt.
// - Stop-on-match halts counting at the match value, optional interrupt.
// - Reset-on-match returns the count to zero, optional interrupt.
// - Each match drives its output low, high, toggled or unchanged.
// - A capture input transition copies the count into the capture register.
// - A capture event may raise an interrupt when software enables it.
// - A designated capture edge clears both count and prescaler.
// - All flags combine onto one interrupt line; flags stay readable.
module match_capture_counter_timer
    import timer_pkg::*;
#(
    parameter int COUNT_W = 32
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [DATA_W-1:0]      rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              count_in,
    input  wire logic              capture_in,
    output logic [NUM_MATCH-1:0]   match_out,
    output logic                   irq
);

    // ==========================================================
    // Elaboration check
    generate
        if (!(COUNT_W == 16 || COUNT_W == 32)) begin : g_bad_width
            $error("COUNT_W must be 16 or 32");
        end
        // Package layout must agree with the match count, or bits overlap
        if (NUM_MATCH * MC_STRIDE > MC_W) begin : g_bad_mc
            $error("match control field too narrow");
        end
        if (FLAG_W != NUM_MATCH + 1 || FLAG_CAPTURE != NUM_MATCH) begin : g_bad_flags
            $error("flag layout does not fit the match count");
        end
        if (3 * NUM_MATCH > DATA_W || CTRL_W > DATA_W || EM_ACTION_LSB != NUM_MATCH) begin : g_bad_map
            $error("register fields exceed the data word");
        end
    endgenerate

    // ==========================================================
    // All module state in one record
    typedef struct packed {
        logic [CTRL_W-1:0]                   ctrl;
        logic [COUNT_W-1:0]                  count;
        logic [COUNT_W-1:0]                  prescale;
        logic [COUNT_W-1:0]                  prescale_count;
        logic [MC_W-1:0]                     match_ctrl;
        logic [NUM_MATCH-1:0]                ext_state;
        logic [2*NUM_MATCH-1:0]              ext_action;
        logic [FLAG_W-1:0]                   flags;
        logic [COUNT_W-1:0]                  capture;
        logic [NUM_MATCH-1:0][COUNT_W-1:0]   match;
        logic                                count_in_prev;
        logic                                capture_in_prev;
        logic                                aw_held;
        logic [ADDR_W-1:0]                   aw_addr;
        logic                                w_held;
        logic [DATA_W-1:0]                   w_data;
        logic [3:0]                          w_strb;
        logic                                bvalid;
        logic [1:0]                          bresp;
        logic                                rvalid;
        logic [1:0]                          rresp;
        logic [DATA_W-1:0]                   rdata;
    } state_t;

    state_t               state_reg;
    state_t               state_next;
    logic                 run;
    logic                 count_evt;
    logic                 tick;
    logic                 cap_evt;
    logic                 clr_evt;
    logic [NUM_MATCH-1:0] hit;
    logic [NUM_MATCH-1:0] ext_next;
    logic [NUM_MATCH-1:0] int_en;
    logic [NUM_MATCH-1:0] reset_en;
    logic [NUM_MATCH-1:0] stop_en;

    // Byte-lane merge of a write into an old register value
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] data,
                                                input logic [3:0]        strb);
        logic [DATA_W-1:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction

    // ==========================================================
    // Event decode
    // Pins are sampled as synchronous, so one previous sample suffices
    assign run       = state_reg.ctrl[CTRL_ENABLE] && !state_reg.ctrl[CTRL_RESET];
    assign count_evt = state_reg.ctrl[CTRL_CNT_MODE]
                     ? edge_hit(state_reg.ctrl[CTRL_CNT_EDGE +: 2],
                                state_reg.count_in_prev, count_in)
                     : 1'b1;
    assign tick      = run && count_evt
                     && (state_reg.prescale_count == state_reg.prescale);
    assign cap_evt   = edge_hit(state_reg.ctrl[CTRL_CAP_EDGE +: 2],
                                state_reg.capture_in_prev, capture_in);
    assign clr_evt   = edge_hit(state_reg.ctrl[CTRL_CLR_EDGE +: 2],
                                state_reg.capture_in_prev, capture_in);

    // ==========================================================
    // Match channels
    genvar gi;
    generate
        for (gi = 0; gi < NUM_MATCH; gi++) begin : g_match
            assign int_en[gi]   = state_reg.match_ctrl[gi*MC_STRIDE + MC_INT];
            assign reset_en[gi] = state_reg.match_ctrl[gi*MC_STRIDE + MC_RESET];
            assign stop_en[gi]  = state_reg.match_ctrl[gi*MC_STRIDE + MC_STOP];
            match_unit #(
                .WIDTH    (COUNT_W)
            ) u_match (
                .count    (state_reg.count),
                .value    (state_reg.match[gi]),
                .tick     (tick),
                .action   (state_reg.ext_action[2*gi +: 2]),
                .out_cur  (state_reg.ext_state[gi]),
                .hit      (hit[gi]),
                .out_next (ext_next[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Next-state logic: counting, then register writes, then flags, then register reads
    always_comb begin
        logic [ADDR_W-1:0]  wa;
        logic [ADDR_W-1:0]  ra;
        logic [FLAG_W-1:0]  set_mask;
        logic [FLAG_W-1:0]  clr_mask;
        logic [DATA_W-1:0]  rd;
        logic               rd_ok;
        logic               do_write;
        wa       = {state_reg.aw_addr[ADDR_W-1:2], 2'b00};
        ra       = {araddr[ADDR_W-1:2], 2'b00};
        set_mask = '0;
        clr_mask = '0;
        rd       = '0;
        rd_ok    = 1'b1;
        do_write = state_reg.aw_held && state_reg.w_held;
        state_next = state_reg;
        state_next.count_in_prev   = count_in;
        state_next.capture_in_prev = capture_in;

        // Prescaler divides the counting events
        if (run && count_evt) begin
            state_next.prescale_count = tick ? '0
                                      : state_reg.prescale_count + 1'b1;
        end

        // Count advance with match actions; reset outranks stop
        if (tick) begin
            if (|(hit & reset_en)) begin
                state_next.count = '0;
            end else if (|(hit & stop_en)) begin
                state_next.count = state_reg.count;
            end else begin
                state_next.count = state_reg.count + 1'b1;
            end
        end
        if (|(hit & stop_en)) begin
            state_next.ctrl[CTRL_ENABLE] = 1'b0;
        end
        state_next.ext_state = ext_next;
        set_mask[NUM_MATCH-1:0] = hit & int_en;

        // Capture snapshot and optional clear for pulse-width measurement
        if (cap_evt) begin
            state_next.capture = state_reg.count;
            set_mask[FLAG_CAPTURE] = state_reg.ctrl[CTRL_CAP_INT];
        end
        if (clr_evt || state_reg.ctrl[CTRL_RESET]) begin
            state_next.count          = '0;
            state_next.prescale_count = '0;
        end

        // Write channels: each is taken independently and held
        if (awvalid && awready) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            state_next.w_held = 1'b1;
            state_next.w_data = wdata;
            state_next.w_strb = wstrb;
        end

        // Register write; software wins over the hardware update, except in the flags, where a new event wins over a clear
        if (do_write) begin
            state_next.aw_held = 1'b0;
            state_next.w_held  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = RESP_OKAY;
            case (wa)
                OFF_CTRL: state_next.ctrl = CTRL_W'(merge(DATA_W'(state_reg.ctrl),
                    state_reg.w_data, state_reg.w_strb));
                OFF_COUNT: state_next.count = COUNT_W'(merge(DATA_W'(state_reg.count),
                    state_reg.w_data, state_reg.w_strb));
                OFF_PRESCALE: state_next.prescale = COUNT_W'(merge(
                    DATA_W'(state_reg.prescale), state_reg.w_data, state_reg.w_strb));
                OFF_PRESCALE_COUNT: state_next.bresp = RESP_OKAY;   // Read-only, ignored
                OFF_MATCH_CTRL: state_next.match_ctrl = MC_W'(merge(
                    DATA_W'(state_reg.match_ctrl), state_reg.w_data, state_reg.w_strb));
                OFF_EXT_MATCH: begin
                    {state_next.ext_action, state_next.ext_state} =
                        (2*NUM_MATCH+NUM_MATCH)'(merge(
                        DATA_W'({state_reg.ext_action, state_reg.ext_state}),
                        state_reg.w_data, state_reg.w_strb));
                end
                OFF_INT_FLAGS: begin
                    // Write one to clear, lowest byte lane only
                    if (state_reg.w_strb[0]) begin
                        clr_mask = state_reg.w_data[FLAG_W-1:0];
                    end
                end
                OFF_CAPTURE: state_next.bresp = RESP_OKAY;          // Read-only, ignored
                default: begin
                    if (wa[5:4] == MATCH_BANK) begin
                        state_next.match[wa[3:2]] = COUNT_W'(merge(
                            DATA_W'(state_reg.match[wa[3:2]]),
                            state_reg.w_data, state_reg.w_strb));
                    end else begin
                        state_next.bresp = RESP_SLVERR;
                    end
                end
            endcase
        end
        if (state_reg.bvalid && bready) begin
            state_next.bvalid = 1'b0;
        end

        // Sticky flags: a new event wins over a clear in the same cycle
        state_next.flags = (state_reg.flags & ~clr_mask) | set_mask;

        // Register read, answered one edge after the address is taken
        case (ra)
            OFF_CTRL:           rd = DATA_W'(state_reg.ctrl);
            OFF_COUNT:          rd = DATA_W'(state_reg.count);
            OFF_PRESCALE:       rd = DATA_W'(state_reg.prescale);
            OFF_PRESCALE_COUNT: rd = DATA_W'(state_reg.prescale_count);
            OFF_MATCH_CTRL:     rd = DATA_W'(state_reg.match_ctrl);
            OFF_EXT_MATCH:      rd = DATA_W'({state_reg.ext_action, state_reg.ext_state});
            OFF_INT_FLAGS:      rd = DATA_W'(state_reg.flags);
            OFF_CAPTURE:        rd = DATA_W'(state_reg.capture);
            default: begin
                if (ra[5:4] == MATCH_BANK) begin
                    rd = DATA_W'(state_reg.match[ra[3:2]]);
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
        if (arvalid && arready) begin
            state_next.rvalid = 1'b1;
            state_next.rdata  = rd_ok ? rd : '0;
            state_next.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (state_reg.rvalid && rready) begin
            state_next.rvalid = 1'b0;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg      <= '0;
            state_reg.ctrl <= CTRL_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs
    // One write in flight keeps the slave simple; throughput is not a goal here
    assign awready   = !state_reg.aw_held && !state_reg.bvalid;
    assign wready    = !state_reg.w_held && !state_reg.bvalid;
    assign bvalid    = state_reg.bvalid;
    assign bresp     = state_reg.bresp;
    assign arready   = !state_reg.rvalid;
    assign rvalid    = state_reg.rvalid;
    assign rdata     = state_reg.rdata;
    assign rresp     = state_reg.rresp;
    assign match_out = state_reg.ext_state;
    assign irq       = |state_reg.flags;

endmodule

`default_nettype wire

//--- rtl/timer_pkg.sv
// Shared constants for the match/capture counter-timer
`default_nettype none
package timer_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam int         ADDR_W             = 6;
    localparam int         DATA_W             = 32;
    localparam logic [5:0] OFF_CTRL           = 6'h00;
    localparam logic [5:0] OFF_COUNT          = 6'h04;
    localparam logic [5:0] OFF_PRESCALE       = 6'h08;
    localparam logic [5:0] OFF_PRESCALE_COUNT = 6'h0C;
    localparam logic [5:0] OFF_MATCH_CTRL     = 6'h10;
    localparam logic [5:0] OFF_EXT_MATCH      = 6'h14;
    localparam logic [5:0] OFF_INT_FLAGS      = 6'h18;
    localparam logic [5:0] OFF_CAPTURE        = 6'h1C;
    localparam logic [1:0] MATCH_BANK         = 2'h2;  // Offsets 0x20..0x2C, one per match

    // ==========================================================
    // Field layout
    localparam int NUM_MATCH      = 4;
    localparam int CTRL_W         = 10;
    localparam int CTRL_ENABLE    = 0;
    localparam int CTRL_RESET     = 1;
    localparam int CTRL_CNT_MODE  = 2;
    localparam int CTRL_CNT_EDGE  = 3;   // Two bits
    localparam int CTRL_CAP_EDGE  = 5;   // Two bits
    localparam int CTRL_CAP_INT   = 7;
    localparam int CTRL_CLR_EDGE  = 8;   // Two bits
    localparam int MC_INT         = 0;
    localparam int MC_RESET       = 1;
    localparam int MC_STOP        = 2;
    localparam int MC_STRIDE      = 3;
    localparam int MC_W           = 12;
    localparam int EM_ACTION_LSB  = 4;
    localparam int FLAG_W         = 5;
    localparam int FLAG_CAPTURE   = 4;

    // ==========================================================
    // Encodings and reset values
    localparam logic [1:0] EDGE_NONE   = 2'h0;
    localparam logic [1:0] EDGE_RISE   = 2'h1;
    localparam logic [1:0] EDGE_FALL   = 2'h2;
    localparam logic [1:0] EDGE_BOTH   = 2'h3;
    localparam logic [1:0] EXT_NOTHING = 2'h0;
    localparam logic [1:0] EXT_LOW     = 2'h1;
    localparam logic [1:0] EXT_HIGH    = 2'h2;
    localparam logic [1:0] EXT_TOGGLE  = 2'h3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

    // Edge detector against a selected polarity
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic       prev,
                                      input logic       cur);
        logic rise;
        logic fall;
        rise = !prev && cur;
        fall = prev && !cur;
        case (sel)
            EDGE_RISE: edge_hit = rise;
            EDGE_FALL: edge_hit = fall;
            EDGE_BOTH: edge_hit = rise || fall;
            default:   edge_hit = 1'b0;
        endcase
    endfunction

endpackage

`default_nettype wire

//--- rtl/match_unit.sv
// One match comparator with its external output action
`timescale 1ns/10ps
`default_nettype none

module match_unit
    import timer_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input  wire logic [WIDTH-1:0] count,
    input  wire logic [WIDTH-1:0] value,
    input  wire logic             tick,
    input  wire logic [1:0]       action,
    input  wire logic             out_cur,
    output logic                  hit,
    output logic                  out_next
);

    // ==========================================================
    // Compare only on an advancing tick, so one match fires once
    assign hit = tick && (count == value);

    // Output action applied on a hit
    always_comb begin
        out_next = out_cur;
        if (hit) begin
            case (action)
                EXT_LOW:    out_next = 1'b0;
                EXT_HIGH:   out_next = 1'b1;
                EXT_TOGGLE: out_next = !out_cur;
                default:    out_next = out_cur;
            endcase
        end
    end

endmodule

`default_nettype wire

//--- test/match_capture_counter_timer_asserts.sv
// Port-level checker for the counter-timer
`timescale 1ns/10ps
`default_nettype none
module match_capture_counter_timer_asserts
    import timer_pkg::*;
(
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic                 awvalid,
    input wire logic                 awready,
    input wire logic                 wvalid,
    input wire logic                 wready,
    input wire logic [1:0]           bresp,
    input wire logic                 bvalid,
    input wire logic                 bready,
    input wire logic [ADDR_W-1:0]    araddr,
    input wire logic                 arvalid,
    input wire logic                 arready,
    input wire logic [DATA_W-1:0]    rdata,
    input wire logic [1:0]           rresp,
    input wire logic                 rvalid,
    input wire logic                 rready,
    input wire logic [NUM_MATCH-1:0] match_out,
    input wire logic                 irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [ADDR_W-1:0] ar_q;
    // ==========================================
    // Address of the read under way
    always_ff @(posedge aclk) begin
        if (arvalid && arready) ar_q <= araddr;
    end
    sequence s_wtake; awvalid && awready && wvalid && wready; endsequence
    sequence s_bdelay; !bvalid ##1 bvalid; endsequence
    chk_write_resp: assert property (s_wtake |=> s_bdelay)
        else $error("write response not on second edge");
    chk_read_resp: assert property (arvalid && arready |=> rvalid)
        else $error("read response late");
    chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable({rresp, rdata}))
        else $error("read response dropped early");
    chk_write_block: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    chk_read_block: assert property (rvalid |-> !arready)
        else $error("read taken while response pending");
    chk_bad_read: assert property (arvalid && arready && araddr > 6'h2F
        |=> rresp == RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    // Irq sampled one cycle back lines up with the flags the read saw
    chk_irq_flags: assert property ($rose(rvalid) && ar_q == OFF_INT_FLAGS
        |-> $past(irq) == (rdata[FLAG_W-1:0] != 5'h00))
        else $error("irq differs from flags");
    chk_reset_quiet: assert property ($rose(aresetn)
        |-> match_out == 4'h0 && !irq && !bvalid && !rvalid)
        else $error("outputs not idle after reset");
endmodule
bind match_capture_counter_timer match_capture_counter_timer_asserts i_chk (.*);
`default_nettype wire

//--- test/pin_model.sv
// External pins model: count pulses and capture level
`timescale 1ns/10ps
`default_nettype none
module pin_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       start,
    input  wire logic [7:0] pulses,
    input  wire logic       cap_req,
    output logic            count_in,
    output logic            capture_in,
    output logic            busy
);
    logic [7:0] left;
    assign busy = left != 8'h00;
    // Two clocks per pulse so every edge is seen by the sampler
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            left       <= 8'h00;
            count_in   <= 1'b0;
            capture_in <= 1'b0;
        end else begin
            capture_in <= cap_req;
            if (start) begin
                left <= pulses;
            end else if (busy) begin
                count_in <= !count_in;
                if (count_in) left <= left - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- test/match_capture_counter_timer_bench.sv
// Self-checking bench for the counter-timer
`timescale 1ns/10ps
`default_nettype none
module match_capture_counter_timer_bench;
    import timer_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, start = 1'b0, cap_req = 1'b0;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0, seed = 32'h2B7192DB, k, p;
    logic [7:0] pulses = 8'h00;
    logic awready, wready, bvalid, arready, rvalid, count_in, capture_in, irq, busy;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] match_out;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    int error_cnt = 0, tests_run = 0, cyc = 0;
    always #4 aclk = !aclk;
    match_capture_counter_timer i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .count_in(count_in), .capture_in(capture_in),
        .match_out(match_out), .irq(irq));
    pin_model i_pins (.aclk(aclk), .aresetn(aresetn), .start(start), .pulses(pulses),
        .cap_req(cap_req), .count_in(count_in), .capture_in(capture_in), .busy(busy));
    // ==========================================
    // Helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Sample at the falling edge, act after the rising edge: no race with the design
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ha, hw, hb;
        @(posedge aclk);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid;
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end while (!hb);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ha, hr;
        @(posedge aclk);
        rq.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ha = arready;
            hr = rvalid;
            @(posedge aclk);
            if (ha) arvalid <= 1'b0;
        end while (!hr);
        rready <= 1'b0;
    endtask
    task automatic pulse(input logic [7:0] n);
        @(posedge aclk);
        pulses <= n;
        start <= 1'b1;
        @(posedge aclk);
        start <= 1'b0;
        @(negedge aclk);
        while (busy) @(negedge aclk);
        repeat (4) @(posedge aclk);
    endtask
    // Response watcher takes the oldest note per answer
    always @(negedge aclk) begin
        if (bvalid && bready) chk("bresp", bq.pop_front(), bresp);
        if (rvalid && rready) chk("rdata", rq.pop_front(), {rresp, rdata});
    end
    // Hang guard at 8000 cycles, a few hundred cycles of traffic expected
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // ==========================================
    // Scenarios
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 12; i++) rd(6'(4 * i), 32'h0, RESP_OKAY);
        rd(6'h30, 32'h0, RESP_SLVERR);
        wr(6'h30, 32'h1, RESP_SLVERR);
        wr(OFF_CAPTURE, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFF_CAPTURE, 32'h0, RESP_OKAY);
        $display("test reset_map done");
        p = xs() & 32'h3;
        k = 8 + (xs() & 32'hF);
        wr(OFF_PRESCALE, p, RESP_OKAY);
        wr(OFF_CTRL, 32'h2, RESP_OKAY);
        wr(OFF_CTRL, 32'hD, RESP_OKAY);
        pulse(k[7:0]);
        rd(OFF_COUNT, k / (p + 1), RESP_OKAY);
        rd(OFF_PRESCALE_COUNT, k % (p + 1), RESP_OKAY);
        $display("test prescale_count done");
        k = 5 + (xs() & 32'h1F);
        wr(OFF_CTRL, 32'h2, RESP_OKAY);
        wr(OFF_PRESCALE, 32'h0, RESP_OKAY);
        wr(6'h20, k, RESP_OKAY);
        wr(OFF_MATCH_CTRL, 32'h4, RESP_OKAY);
        wr(OFF_CTRL, 32'h1, RESP_OKAY);
        repeat (60) @(posedge aclk);
        rd(OFF_COUNT, k, RESP_OKAY);
        rd(OFF_CTRL, 32'h0, RESP_OKAY);
        $display("test timer_stop done");
        wr(OFF_CTRL, 32'h2, RESP_OKAY);
        for (int i = 0; i < 4; i++) wr(6'h20 + 6'(4 * i), 32'h5, RESP_OKAY);
        wr(OFF_MATCH_CTRL, 32'h24B, RESP_OKAY);
        wr(OFF_EXT_MATCH, 32'hE43, RESP_OKAY);
        wr(OFF_CTRL, 32'hD, RESP_OKAY);
        pulse(8'h08);
        rd(OFF_COUNT, 32'h2, RESP_OKAY);
        chk("match_out", 34'hD, match_out);
        chk("irq", 34'h1, irq);
        rd(OFF_INT_FLAGS, 32'hF, RESP_OKAY);
        wr(OFF_INT_FLAGS, 32'h1F, RESP_OKAY);
        rd(OFF_INT_FLAGS, 32'h0, RESP_OKAY);
        chk("irq", 34'h0, irq);
        $display("test match_actions done");
        k = 8 + (xs() & 32'hF);
        wr(OFF_MATCH_CTRL, 32'h0, RESP_OKAY);
        wr(OFF_CTRL, 32'h0, RESP_OKAY);
        wr(OFF_COUNT, 32'h64, RESP_OKAY);
        wr(OFF_CTRL, 32'h1CD, RESP_OKAY);
        @(posedge aclk);
        cap_req <= 1'b1;
        repeat (3) @(posedge aclk);
        pulse(k[7:0]);
        cap_req <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(OFF_CAPTURE, k, RESP_OKAY);
        rd(OFF_INT_FLAGS, 32'h10, RESP_OKAY);
        chk("irq", 34'h1, irq);
        $display("test capture_clear done");
        give_verdict();
    end
endmodule
`default_nettype wire
